/* bor_reset_ctrl.sv */
// brown-out and power-on reset mode control with an AXI4-Lite register slave
// assumes detector outputs already synchronous to aclk; one write, one read at a time
//
// Overview of operation
// - mode b11 keeps brown-out detection enabled in every state
// - mode b11 keeps brown-out protection active during sleep
// - mode b11 wake from sleep does not wait for ready
// - modes b11 and b10 start-up waits for ready and supply above threshold
// - mode b10 detection enabled awake, hibernating in sleep
// - mode b10 never issues brown-out reset during sleep
// - mode b10 wake from sleep stalls until ready is set
// - mode b01 detection follows the software enable bit
// - mode b01 start-up waits neither for ready nor supply
// - mode b01 protection starts once ready; ready readable in status
// - mode b01 software enable state unaffected by sleep entry or exit
// - mode b00 detection off permanently, start-up without ready wait
// - mode b11 ready flag set before cpu runs, no extra wait
// - hold reset while power-on detector reports low supply
// - hold reset while enabled brown-out detector reports low supply once ready is set
// - power-on reset clears the active-low power-on cause flag
// - brown-out reset clears the active-low brown-out cause flag
`timescale 1ns/100ps
module bor_reset_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] brownout_mode_cfg,
	input wire logic por_low,
	input wire logic bor_low,
	input wire logic bor_circuit_ready,
	input wire logic sleep_req,
	input wire logic wake_req,
	output logic bor_detector_enable,
	output logic device_reset,
	output logic cpu_run,
	output logic irq,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef enum logic [1:0] {ST_RESET, ST_START, ST_RUN, ST_SLEEP} bor_state_e;

	bor_state_e state_q;
	bor_gate_if gi ();
	logic sw_brownout_enable_q;
	logic brownout_ready_flag;
	logic brownout_reset_flag_n_q;
	logic por_flag_n_q;
	logic bor_req;
	logic hold_reset;
	logic [1:0] hold_cnt_q;
	logic [bor_pkg::IRQ_W-1:0] irq_stat_q;
	logic [bor_pkg::IRQ_W-1:0] irq_mask_q;
	logic [bor_pkg::IRQ_W-1:0] irq_evt;
	logic ready_q;
	logic aw_held_q;
	logic w_held_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic wstrb_lo_q;
	logic wake_pend_q;
	logic wr_fire;
	logic rd_fire;
	logic [31:0] rd_val;
	logic rd_ok;

	// =========================================================
	// mode decode
	// =========================================================
	assign gi.mode = brownout_mode_cfg;
	assign gi.sw_en = sw_brownout_enable_q;
	// a pending wake in mode b10 turns the detector back on to reach ready
	assign gi.sleeping = (state_q == ST_SLEEP) && !wake_pend_q;

	bor_mode_decode u_decode (
		.gi(gi)
	);

	assign brownout_ready_flag = bor_circuit_ready;
	assign bor_detector_enable = gi.det_enable;
	// protection in effect only once the circuit reports ready
	// no brown-out reset while still asleep and waiting for ready
	assign bor_req = gi.det_enable && brownout_ready_flag && bor_low
		&& !(state_q == ST_SLEEP && wake_pend_q);
	assign hold_reset = por_low || bor_req;
	assign device_reset = hold_reset || (state_q == ST_RESET);
	assign cpu_run = (state_q == ST_RUN);

	// =========================================================
	// start / sleep sequencer
	// =========================================================
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_RESET;
			hold_cnt_q <= '0;
		end else if (hold_reset) begin
			state_q <= ST_RESET;
			hold_cnt_q <= '0;
		end else begin
			unique case (state_q)
				ST_RESET: begin
					if (hold_cnt_q == 2'(bor_pkg::RUN_HOLD_CYC - 1)) begin
						state_q <= ST_START;
					end else begin
						hold_cnt_q <= hold_cnt_q + 2'h1;
					end
				end
				ST_START: begin
					// wait for ready and supply above threshold when required
					if (!gi.start_wait || (brownout_ready_flag && !bor_low)) begin
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (sleep_req) begin
						state_q <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if ((wake_req || wake_pend_q)
						&& (!gi.wake_wait || brownout_ready_flag)) begin
						state_q <= ST_RUN;
					end
				end
			endcase
		end
	end

	// a wake request that must wait for ready is kept until sleep is left
	always_ff @(posedge aclk) begin
		if (!aresetn || state_q != ST_SLEEP) begin
			wake_pend_q <= 1'b0;
		end else if (wake_req && gi.wake_wait) begin
			wake_pend_q <= 1'b1;
		end
	end

	// =========================================================
	// reset cause flags
	// =========================================================
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_flag_n_q <= 1'b0;
			brownout_reset_flag_n_q <= 1'b1;
		end else begin
			if (por_low) begin
				por_flag_n_q <= 1'b0;
			end else if (wr_fire && awaddr_q == bor_pkg::OFF_CTRL && wdata_q[bor_pkg::CTRL_RST_POR_BIT]) begin
				por_flag_n_q <= 1'b1;
			end
			if (bor_req) begin
				brownout_reset_flag_n_q <= 1'b0;
			end else if (wr_fire && awaddr_q == bor_pkg::OFF_CTRL && wdata_q[bor_pkg::CTRL_RST_BOR_BIT]) begin
				brownout_reset_flag_n_q <= 1'b1;
			end
		end
	end

	// =========================================================
	// software enable, untouched by sleep
	// =========================================================
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_brownout_enable_q <= bor_pkg::CTRL_SW_EN_RST;
		end else if (wr_fire && awaddr_q == bor_pkg::OFF_CTRL && wstrb_lo_q) begin
			sw_brownout_enable_q <= wdata_q[bor_pkg::CTRL_SW_EN_BIT];
		end
	end

	// =========================================================
	// interrupts
	// =========================================================
	always_comb begin
		irq_evt = '0;
		irq_evt[bor_pkg::IRQ_POR_BIT] = por_low;
		irq_evt[bor_pkg::IRQ_BOR_BIT] = bor_req;
		irq_evt[bor_pkg::IRQ_READY_BIT] = brownout_ready_flag && !ready_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ready_q <= 1'b0;
			irq_stat_q <= '0;
		end else begin
			ready_q <= brownout_ready_flag;
			// a new event wins over the read clear
			if (rd_fire && {s_axi_araddr[11:2], 2'h0} == bor_pkg::OFF_IRQ_STAT) begin
				irq_stat_q <= irq_evt;
			end else begin
				irq_stat_q <= irq_stat_q | irq_evt;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_q <= bor_pkg::IRQ_MASK_RST;
		end else if (wr_fire && awaddr_q == bor_pkg::OFF_IRQ_MASK) begin
			irq_mask_q <= wdata_q[bor_pkg::IRQ_W-1:0];
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	// =========================================================
	// AXI4-Lite write channel
	// =========================================================
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign wr_fire = aw_held_q && w_held_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_lo_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= bor_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= {s_axi_awaddr[11:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_lo_q <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q == bor_pkg::OFF_CTRL || awaddr_q == bor_pkg::OFF_IRQ_MASK)
					? bor_pkg::RESP_OKAY : bor_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// =========================================================
	// AXI4-Lite read channel
	// =========================================================
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	always_comb begin
		rd_val = '0;
		rd_ok = 1'b1;
		unique case ({s_axi_araddr[11:2], 2'h0})
			bor_pkg::OFF_CTRL: begin
				rd_val[bor_pkg::CTRL_SW_EN_BIT] = sw_brownout_enable_q;
			end
			bor_pkg::OFF_STAT: begin
				rd_val[bor_pkg::STAT_READY_BIT] = brownout_ready_flag;
				rd_val[bor_pkg::STAT_POR_N_BIT] = por_flag_n_q;
				rd_val[bor_pkg::STAT_BOR_N_BIT] = brownout_reset_flag_n_q;
				rd_val[bor_pkg::STAT_ACTIVE_BIT] = gi.det_enable;
				rd_val[bor_pkg::STAT_RESET_BIT] = device_reset;
				rd_val[bor_pkg::STAT_RUN_BIT] = cpu_run;
				rd_val[bor_pkg::STAT_MODE_LSB +: 2] = brownout_mode_cfg;
			end
			bor_pkg::OFF_IRQ_STAT: begin
				rd_val[bor_pkg::IRQ_W-1:0] = irq_stat_q;
			end
			bor_pkg::OFF_IRQ_MASK: begin
				rd_val[bor_pkg::IRQ_W-1:0] = irq_mask_q;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= bor_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_ok ? bor_pkg::RESP_OKAY : bor_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// =========================================================
	// checks
	// =========================================================
	AST_ON_ALWAYS: assert property (@(posedge aclk) disable iff (!aresetn)
		brownout_mode_cfg == bor_pkg::MODE_ON |-> bor_detector_enable)
		else $error("detector not enabled in always-on mode");
	AST_ON_SLEEP: assert property (@(posedge aclk) disable iff (!aresetn)
		(brownout_mode_cfg == bor_pkg::MODE_ON && state_q == ST_SLEEP && bor_low
		&& bor_circuit_ready) |-> device_reset)
		else $error("no protection in sleep for always-on mode");
	AST_ON_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
		(brownout_mode_cfg == bor_pkg::MODE_ON && state_q == ST_SLEEP && wake_req
		&& !hold_reset) |=> cpu_run)
		else $error("wake held back in always-on mode");
	AST_START_WAIT: assert property (@(posedge aclk) disable iff (!aresetn)
		($rose(cpu_run) && $past(state_q) == ST_START && brownout_mode_cfg[1])
		|-> $past(bor_circuit_ready) && !$past(bor_low))
		else $error("start-up ran without ready");
	AST_NOSLEEP_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
		(brownout_mode_cfg == bor_pkg::MODE_NOSLEEP)
		|-> bor_detector_enable == (state_q != ST_SLEEP || wake_pend_q))
		else $error("b10 enable wrong");
	AST_NOSLEEP_NORST: assert property (@(posedge aclk) disable iff (!aresetn)
		(brownout_mode_cfg == bor_pkg::MODE_NOSLEEP && state_q == ST_SLEEP && !por_low)
		|-> !device_reset)
		else $error("brown-out reset in sleep for b10");
	AST_NOSLEEP_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
		(brownout_mode_cfg == bor_pkg::MODE_NOSLEEP && state_q == ST_SLEEP
		&& !bor_circuit_ready) |=> !cpu_run)
		else $error("b10 wake without ready");
	AST_SW_EN: assert property (@(posedge aclk) disable iff (!aresetn)
		brownout_mode_cfg == bor_pkg::MODE_SW |-> bor_detector_enable == sw_brownout_enable_q)
		else $error("b01 enable not software bit");
	AST_SW_START: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_q == ST_START && !hold_reset && !brownout_mode_cfg[1]) |=> cpu_run)
		else $error("start-up delayed in b01 or b00");
	AST_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
		brownout_mode_cfg == bor_pkg::MODE_OFF |-> !bor_detector_enable)
		else $error("detector on in b00");
	AST_POR_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		por_low |-> device_reset ##1 (!cpu_run))
		else $error("no reset on low supply");
	AST_BOR_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
		bor_req |=> !brownout_reset_flag_n_q)
		else $error("brown-out flag not cleared");
	AST_POR_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
		por_low |=> !por_flag_n_q)
		else $error("power-on flag not cleared");
	AST_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
		(!bor_detector_enable && !por_low) |-> !hold_reset)
		else $error("disabled detector caused reset");
	COV_RUN: cover property (@(posedge aclk) disable iff (!aresetn) $rose(cpu_run));
	COV_WAKE: cover property (@(posedge aclk) disable iff (!aresetn)
		state_q == ST_SLEEP ##1 state_q == ST_RUN);
	COV_BOR: cover property (@(posedge aclk) disable iff (!aresetn) bor_req);
endmodule : bor_reset_ctrl

/* bor_pkg.sv */
// package for the brown-out reset mode control block
// assumes a single 125 MHz system clock and no other package
package bor_pkg;
	// brown-out mode configuration encodings
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SW = 2'h1;
	localparam logic [1:0] MODE_NOSLEEP = 2'h2;
	localparam logic [1:0] MODE_ON = 2'h3;
	// register byte offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STAT = 12'h004;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;
	// control register fields
	localparam int CTRL_SW_EN_BIT = 0;
	localparam int CTRL_RST_POR_BIT = 1;
	localparam int CTRL_RST_BOR_BIT = 2;
	// status register fields
	localparam int STAT_READY_BIT = 0;
	localparam int STAT_POR_N_BIT = 1;
	localparam int STAT_BOR_N_BIT = 2;
	localparam int STAT_ACTIVE_BIT = 3;
	localparam int STAT_RESET_BIT = 4;
	localparam int STAT_RUN_BIT = 5;
	localparam int STAT_MODE_LSB = 8;
	// interrupt event bits
	localparam int IRQ_POR_BIT = 0;
	localparam int IRQ_BOR_BIT = 1;
	localparam int IRQ_READY_BIT = 2;
	localparam int IRQ_W = 3;
	// reset values
	localparam logic CTRL_SW_EN_RST = 1'b0;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// least time from reset release to run, in ns
	localparam int RUN_HOLD_NS = 16;
	localparam int CLK_PERIOD_NS = 8;
	localparam int RUN_HOLD_CYC = (RUN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : bor_pkg

/* bor_gate_if.sv */
// carrier between the mode control and its enable decoder
// assumes both ends share one clock
`timescale 1ns/100ps
interface bor_gate_if;
	logic [1:0] mode;
	logic sw_en;
	logic sleeping;
	logic det_enable;
	logic start_wait;
	logic wake_wait;
	modport ctl (output mode, output sw_en, output sleeping,
		input det_enable, input start_wait, input wake_wait);
	modport dec (input mode, input sw_en, input sleeping,
		output det_enable, output start_wait, output wake_wait);
endinterface : bor_gate_if

/* bor_mode_decode.sv */
// decoder of effective brown-out enable and ready waits from the mode
// assumes purely combinational use inside the mode control block
`timescale 1ns/100ps
module bor_mode_decode (
	bor_gate_if.dec gi
);
	always_comb begin
		unique case (gi.mode)
			bor_pkg::MODE_ON: begin
				gi.det_enable = 1'b1;
				gi.start_wait = 1'b1;
				gi.wake_wait = 1'b0;
			end
			bor_pkg::MODE_NOSLEEP: begin
				gi.det_enable = !gi.sleeping;
				gi.start_wait = 1'b1;
				gi.wake_wait = 1'b1;
			end
			bor_pkg::MODE_SW: begin
				gi.det_enable = gi.sw_en;
				gi.start_wait = 1'b0;
				gi.wake_wait = 1'b0;
			end
			bor_pkg::MODE_OFF: begin
				gi.det_enable = 1'b0;
				gi.start_wait = 1'b0;
				gi.wake_wait = 1'b0;
			end
		endcase
	end
endmodule : bor_mode_decode

/* bor_supply_model.sv */
// model of the supply supervisors: power-on and brown-out comparators
// assumes the bench commands the supply levels and the brown-out ready delay
`timescale 1ns/100ps
module bor_supply_model (
	input wire logic aclk,
	input wire logic det_en,
	input wire logic supply_below_min,
	input wire logic supply_below_thr,
	input wire logic [7:0] ready_dly,
	output logic por_low,
	output logic bor_low,
	output logic bor_circuit_ready
);
	logic [7:0] cnt_q;
	// ================================
	// ready comes a set time after enable; hibernation drops it
	always_ff @(posedge aclk) begin
		if (!det_en)
			cnt_q <= 8'h00;
		else if (cnt_q != 8'hFF)
			cnt_q <= cnt_q + 8'h01;
	end
	assign bor_circuit_ready = det_en && (cnt_q >= ready_dly);
	assign por_low = supply_below_min;
	// raw comparator view, the block must gate it itself
	assign bor_low = supply_below_thr;
endmodule : bor_supply_model

/* tb_brownout_reset_mode_control.sv */
// bench for the brown-out reset mode control block
// assumes the supply model drives the detector inputs
`timescale 1ns/100ps
module tb_brownout_reset_mode_control;
	logic aclk, aresetn, sleep_req, wake_req;
	logic [1:0] brownout_mode_cfg;
	logic por_low, bor_low, bor_circuit_ready, bor_detector_enable;
	logic device_reset, cpu_run, irq;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic below_min, below_thr;
	logic [7:0] rdly;
	int err_total, comparisons, n;

	bor_reset_ctrl uut (.aclk, .aresetn, .brownout_mode_cfg, .por_low, .bor_low,
		.bor_circuit_ready, .sleep_req, .wake_req, .bor_detector_enable, .device_reset,
		.cpu_run, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	bor_supply_model sup (.aclk, .det_en(bor_detector_enable), .supply_below_min(below_min),
		.supply_below_thr(below_thr), .ready_dly(rdly), .por_low, .bor_low,
		.bor_circuit_ready);

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// ================================
	// helpers
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	task automatic fail(input string m);
		err_total++;
		$display("unexpected at %0t: %s", $time, m);
	endtask : fail

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		comparisons++;
		if (g !== e)
			fail(m);
	endtask : chk

	task automatic tick(input int k);
		repeat (k) @(posedge aclk);
	endtask : tick

	task automatic wait_run(input int lim);
		n = 0;
		while (cpu_run !== 1'b1 && n < lim) begin
			tick(1);
			n++;
		end
		if (n >= lim) begin
			fail("run not reached");
			complete_run();
		end
	endtask : wait_run

	task automatic pulse_sleep();
		sleep_req <= 1'b1;
		tick(1);
		sleep_req <= 1'b0;
		tick(2);
	endtask : pulse_sleep

	task automatic do_reset(input logic [1:0] m, input logic [7:0] dl);
		aresetn <= 1'b0;
		brownout_mode_cfg <= m;
		rdly <= dl;
		tick(2);
		aresetn <= 1'b1;
	endtask : do_reset

	// ================================
	// register bus master
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
		logic aw;
		logic w;
		int k;
		aw = 1'b0;
		w = 1'b0;
		k = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw && w) && k < 50) begin
			@(posedge aclk);
			k++;
			if (!aw && s_axi_awready === 1'b1) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready === 1'b1) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
		end while (s_axi_bvalid !== 1'b1 && k < 100);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (k >= 100) begin
			fail("write hang");
			complete_run();
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [11:0] a);
		int k;
		k = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_arvalid && s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && k < 50);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (k >= 50) begin
			fail("read hang");
			complete_run();
		end
	endtask : axi_rd

	// ================================
	// tests
	initial begin
		err_total = 0;
		comparisons = 0;
		aresetn <= 1'b0;
		sleep_req <= 1'b0;
		wake_req <= 1'b0;
		brownout_mode_cfg <= 2'h3;
		s_axi_awaddr <= 12'h000;
		s_axi_araddr <= 12'h000;
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_arvalid <= 1'b0;
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		s_axi_wdata <= 32'h0;
		s_axi_wstrb <= 4'hF;
		below_min <= 1'b0;
		below_thr <= 1'b0;
		rdly <= 8'h0C;
		tick(1);
		for (int m = 0; m < 4; m++) begin
			below_thr <= 1'b1;
			do_reset(m[1:0], 8'h0C);
			tick(30);
			chk(cpu_run, m < 2, "start gating");
			chk(device_reset, m >= 2, "low supply hold");
			chk(bor_detector_enable, m >= 2, "awake enable");
			below_thr <= 1'b0;
			wait_run(40);
			chk(bor_circuit_ready, m >= 2, "ready at start");
			axi_rd(bor_pkg::OFF_STAT);
			chk(d[bor_pkg::STAT_MODE_LSB +: 2], m, "mode field");
			pulse_sleep();
			chk(cpu_run, 1'b0, "sleep entry");
			chk(bor_detector_enable, m == 3, "sleep enable");
			wake_req <= 1'b1;
			tick(1);
			wake_req <= 1'b0;
			wait_run(40);
			chk(cpu_run, 1'b1, "wake");
			if (m == 2) chk(bor_circuit_ready, 1'b1, "wake stall");
			if (m == 3) chk(n < 3, 1'b1, "wake delay");
			axi_wr(bor_pkg::OFF_CTRL, 32'h4);
			pulse_sleep();
			below_thr <= 1'b1;
			tick(3);
			chk(device_reset, m == 3, "sleep brownout");
			below_thr <= 1'b0;
			tick(8);
			axi_rd(bor_pkg::OFF_STAT);
			chk(d[bor_pkg::STAT_BOR_N_BIT], m != 3, "brownout flag");
			$display("test mode %0d done", m);
		end
		do_reset(2'h1, 8'h03);
		wait_run(30);
		axi_wr(bor_pkg::OFF_CTRL, 32'h1);
		tick(6);
		chk(bor_detector_enable, 1'b1, "software enable");
		axi_rd(bor_pkg::OFF_STAT);
		chk(d[bor_pkg::STAT_READY_BIT], 1'b1, "ready bit");
		chk(d[bor_pkg::STAT_ACTIVE_BIT], 1'b1, "protection active");
		pulse_sleep();
		chk(bor_detector_enable, 1'b1, "software enable in sleep");
		below_thr <= 1'b1;
		tick(2);
		chk(device_reset, 1'b1, "software brownout");
		below_thr <= 1'b0;
		tick(8);
		$display("test software mode done");
		do_reset(2'h0, 8'h0C);
		wait_run(30);
		axi_rd(bor_pkg::OFF_CTRL);
		chk(d, 32'h0, "control reset value");
		axi_rd(bor_pkg::OFF_IRQ_MASK);
		chk(d, 32'h0, "mask reset value");
		axi_rd(bor_pkg::OFF_IRQ_STAT);
		axi_wr(bor_pkg::OFF_CTRL, 32'h6);
		axi_rd(bor_pkg::OFF_STAT);
		chk(d[bor_pkg::STAT_POR_N_BIT], 1'b1, "flag set by software");
		axi_wr(bor_pkg::OFF_IRQ_MASK, 32'h1);
		below_min <= 1'b1;
		tick(3);
		chk(device_reset, 1'b1, "power-on hold");
		below_min <= 1'b0;
		wait_run(30);
		chk(irq, 1'b1, "irq raised");
		axi_rd(bor_pkg::OFF_STAT);
		chk(d[bor_pkg::STAT_POR_N_BIT], 1'b0, "power-on flag");
		axi_rd(bor_pkg::OFF_IRQ_STAT);
		chk(d[bor_pkg::IRQ_POR_BIT], 1'b1, "irq status");
		tick(1);
		chk(irq, 1'b0, "irq cleared by read");
		axi_wr(bor_pkg::OFF_IRQ_MASK, 32'h0);
		below_min <= 1'b1;
		tick(3);
		below_min <= 1'b0;
		wait_run(30);
		chk(irq, 1'b0, "irq masked");
		axi_wr(12'h010, 32'h1);
		chk(r, bor_pkg::RESP_SLVERR, "unmapped write");
		axi_rd(12'h010);
		chk(r, bor_pkg::RESP_SLVERR, "unmapped read");
		chk(d, 32'h0, "unmapped data");
		$display("test registers done");
		complete_run();
	end
endmodule : tb_brownout_reset_mode_control
